// ===== fcsi_host.sv
// Host sequencer for an asynchronous flash command interface.
// Assumes software on the plain register port; flash bus pins via the cycle engine, power-down reset and ready/busy pins direct.
// Overview of operation
// - Writes use 40h/10h; erase 20h then D0h
// - Suspend not taken: resume after next erase
// - Lock block only after protect reset
// - Protect set follows every lock block
// - Protect confirm address low bits are 0FFh
// - Check ready before reading result bits
// - Mask reserved status bits 2 to 0
// - Return to array read with FFh
module fcsi_host
(
  input  wire logic                     sys_clk_in,
  input  wire logic                     sys_rst_in,
  input  wire logic [fcsi_pkg::RA_W-1:0] reg_addr_in,
  input  wire logic [fcsi_pkg::R_W-1:0] reg_wdata_in,
  input  wire logic                     reg_wr_in,
  input  wire logic                     reg_rd_in,
  output logic [fcsi_pkg::R_W-1:0]      reg_rdata_out,
  output logic                          flash_ce_n_out,
  output logic                          flash_oe_n_out,
  output logic                          flash_we_n_out,
  output logic [fcsi_pkg::A_W-1:0]      flash_addr_out,
  output logic                          byte_select_addr_out,
  output logic [fcsi_pkg::D_W-1:0]      flash_dq_out,
  output logic                          flash_dq_oe_out,
  input  wire logic [fcsi_pkg::D_W-1:0] flash_dq_in,
  output logic                          powerdown_reset_n_out,
  input  wire logic                     ready_busy_n_in
);
  import fcsi_pkg::*;
  fcsi_cyc_if cyc ();
  fcsi_state_e      state, next_state;
  fcsi_op_t         op, next_op;
  logic [A_W:0]     addr, next_addr;
  logic [D_W-1:0]   wdata, next_wdata, rdata, next_rdata;
  logic [7:0]       stat_byte, next_stat_byte, cnt, next_cnt;
  logic             sent, next_sent, seq_err, next_seq_err, refused, next_refused;
  logic             owe, next_owe, poff, next_poff, pdn, next_pdn, pd_rst_n, next_pd_rst_n;
  logic             req, next_req, req_wr, next_req_wr, req_bsel, next_req_bsel;
  logic [A_W-1:0]   req_addr, next_req_addr;
  logic [D_W-1:0]   req_data, next_req_data;
  logic [R_W-1:0]   reg_rdata, next_reg_rdata, stat_word;
  logic             rb_s1, rb_s2;
  logic             cyc_wr, cyc_bsel, is_read, ctl_wr, rdy;
  logic [A_W-1:0]   cyc_addr;
  logic [D_W-1:0]   cyc_data;
  logic [7:0]       code1;

  assign is_read = (op == OP_READ_ARRAY) || (op == OP_READ_ID) || (op == OP_READ_STAT);
  assign ctl_wr = reg_wr_in && (reg_addr_in == REG_CTRL);
  assign rdy = cyc.rdata[STATUS_RDY];

  always_comb
  begin
    unique case (op)
      OP_READ_ID:   code1 = CMD_READ_ID;
      OP_READ_STAT: code1 = CMD_READ_STAT;
      OP_CLR_STAT:  code1 = CMD_CLR_STAT;
      OP_WORD_WR:   code1 = CMD_WORD_WR;
      OP_ALT_WR:    code1 = CMD_ALT_WR;
      OP_ERASE:     code1 = CMD_ERASE;
      OP_SUSPEND:   code1 = CMD_SUSPEND;
      OP_RESUME:    code1 = CMD_CONFIRM;
      OP_PSET:      code1 = CMD_PSET;
      OP_PRESET:    code1 = CMD_PRESET;
      OP_LOCK:      code1 = CMD_LOCK;
      OP_ERASE_ALL: code1 = CMD_ERASE_ALL;
      OP_TWO_BYTE:  code1 = CMD_TWO_BYTE;
      default:      code1 = CMD_READ_ARRAY;
    endcase
  end

  // Fields of the bus cycle the current state issues
  always_comb
  begin
    cyc_wr = 1'b1;
    cyc_bsel = 1'b0;
    cyc_addr = '0;
    cyc_data = {8'h00, CMD_READ_ARRAY};
    unique case (state)
      S_C1:
        cyc_data = {8'h00, code1};
      S_C2:
      begin
        cyc_addr = addr[A_W-1:0];
        cyc_data = {8'h00, CMD_CONFIRM};
        if (is_read)
          cyc_wr = 1'b0;
        else if (op == OP_PSET || op == OP_PRESET)
          cyc_addr = CONF_ADDR;
        else if (op == OP_ERASE_ALL)
          cyc_addr = '0;
        else if (op == OP_WORD_WR || op == OP_ALT_WR)
          cyc_data = wdata;
        else if (op == OP_TWO_BYTE)
        begin
          cyc_bsel = addr[ADDR_BSEL];
          cyc_data = {8'h00, addr[ADDR_BSEL] ? wdata[15:8] : wdata[7:0]};
        end
      end
      S_C3:
      begin
        cyc_addr = addr[A_W-1:0];
        cyc_bsel = !addr[ADDR_BSEL];
        cyc_data = {8'h00, addr[ADDR_BSEL] ? wdata[7:0] : wdata[15:8]};
      end
      S_STW:
        cyc_data = {8'h00, CMD_READ_STAT};
      S_POLL:
        cyc_wr = 1'b0;
      S_RES:
        cyc_data = {8'h00, CMD_CONFIRM};
      S_IDLE, S_FF, S_PDN:
        cyc_wr = 1'b1;
    endcase
  end

  always_comb
  begin
    next_state = state;
    next_op = op;
    next_addr = addr;
    next_wdata = wdata;
    next_rdata = rdata;
    next_stat_byte = stat_byte;
    next_cnt = cnt;
    next_sent = sent;
    next_seq_err = seq_err;
    next_refused = refused;
    next_owe = owe;
    next_poff = poff;
    next_pdn = pdn;
    next_pd_rst_n = pd_rst_n;
    next_req = 1'b0;
    next_req_wr = req_wr;
    next_req_bsel = req_bsel;
    next_req_addr = req_addr;
    next_req_data = req_data;
    if (ctl_wr && reg_wdata_in[CTL_CLR])
    begin
      next_seq_err = 1'b0;
      next_refused = 1'b0;
    end
    if (state == S_IDLE)
    begin
      if (reg_wr_in && reg_addr_in == REG_ADDR)
        next_addr = reg_wdata_in[A_W:0];
      if (reg_wr_in && reg_addr_in == REG_WDATA)
        next_wdata = reg_wdata_in[D_W-1:0];
      if (ctl_wr && reg_wdata_in[CTL_PDN] && !pdn)
      begin
        next_pdn = 1'b1;
        next_pd_rst_n = 1'b0;
        next_stat_byte = '0;
        next_owe = 1'b0;
        next_poff = 1'b0;
      end
      else if (ctl_wr && !reg_wdata_in[CTL_PDN] && pdn)
      begin
        next_pdn = 1'b0;
        next_pd_rst_n = 1'b1;
        next_cnt = PD_LOAD;
        next_state = S_PDN;
      end
      else if (ctl_wr && reg_wdata_in[CTL_GO])
      begin
        if (pdn || (reg_wdata_in[OP_W-1:0] == OP_LOCK && !poff))
          next_refused = 1'b1;
        else
        begin
          next_op = reg_wdata_in[OP_W-1:0];
          next_sent = 1'b0;
          next_state = S_C1;
        end
      end
    end
    else if (ctl_wr && reg_wdata_in[CTL_GO])
      next_refused = 1'b1;
    if (state == S_PDN)
    begin
      if (cnt == '0)
        next_state = S_IDLE;
      else
        next_cnt = cnt - 8'h01;
    end
    else if (state != S_IDLE)
    begin
      if (!sent)
      begin
        next_req = 1'b1;
        next_sent = 1'b1;
        next_req_wr = cyc_wr;
        next_req_bsel = cyc_bsel;
        next_req_addr = cyc_addr;
        next_req_data = cyc_data;
      end
      if (cyc.done)
      begin
        next_sent = 1'b0;
        unique case (state)
          S_C1:
            if (op == OP_CLR_STAT)
              next_state = S_IDLE;
            else if (op == OP_SUSPEND || op == OP_RESUME)
              next_state = S_STW;
            else
              next_state = S_C2;
          S_C2:
            if (is_read)
            begin
              next_rdata = cyc.rdata;
              next_state = (op == OP_READ_ID) ? S_FF : S_IDLE;
            end
            else
              next_state = (op == OP_TWO_BYTE) ? S_C3 : S_STW;
          S_C3, S_RES:
            next_state = S_STW;
          S_STW:
            next_state = S_POLL;
          S_POLL:
            if (rdy)
            begin
              next_stat_byte = cyc.rdata[7:0] & STATUS_MASK;
              if (cyc.rdata[STATUS_EERR] && cyc.rdata[STATUS_WERR])
                next_seq_err = 1'b1;
              if (op == OP_SUSPEND)
                next_owe = !cyc.rdata[STATUS_SUSP];
              if (op == OP_PRESET)
                next_poff = 1'b1;
              if (op == OP_PSET)
                next_poff = 1'b0;
              if (op == OP_LOCK)
              begin
                next_op = OP_PSET;
                next_state = S_C1;
              end
              else if ((op == OP_ERASE || op == OP_ERASE_ALL) && owe)
              begin
                next_owe = 1'b0;
                next_state = S_RES;
              end
              else
                next_state = S_FF;
            end
          S_FF:
            next_state = S_IDLE;
          S_IDLE, S_PDN:
            next_state = state;
        endcase
      end
    end
  end

  assign stat_word = {17'h00000, pdn, rb_s2, poff, owe, refused, seq_err, state != S_IDLE, stat_byte};

  always_comb
  begin
    next_reg_rdata = '0;
    if (reg_rd_in)
    begin
      unique case (reg_addr_in)
        REG_CTRL:  next_reg_rdata = {28'h0000000, op};
        REG_ADDR:  next_reg_rdata = {13'h0000, addr};
        REG_WDATA: next_reg_rdata = {16'h0000, wdata};
        REG_STAT:  next_reg_rdata = stat_word;
        REG_RDATA: next_reg_rdata = {16'h0000, rdata};
        default:   next_reg_rdata = '0;
      endcase
    end
  end

  always_ff @(posedge sys_clk_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
    begin
      state <= S_IDLE;
      op <= OP_READ_ARRAY;
      addr <= '0;
      wdata <= '0;
      rdata <= '0;
      stat_byte <= '0;
      cnt <= '0;
      sent <= 1'b0;
      seq_err <= 1'b0;
      refused <= 1'b0;
      owe <= 1'b0;
      poff <= 1'b0;
      pdn <= 1'b0;
      pd_rst_n <= 1'b1;
      req <= 1'b0;
      req_wr <= 1'b0;
      req_bsel <= 1'b0;
      req_addr <= '0;
      req_data <= '0;
      reg_rdata <= '0;
      rb_s1 <= 1'b1;
      rb_s2 <= 1'b1;
    end
    else
    begin
      state <= next_state;
      op <= next_op;
      addr <= next_addr;
      wdata <= next_wdata;
      rdata <= next_rdata;
      stat_byte <= next_stat_byte;
      cnt <= next_cnt;
      sent <= next_sent;
      seq_err <= next_seq_err;
      refused <= next_refused;
      owe <= next_owe;
      poff <= next_poff;
      pdn <= next_pdn;
      pd_rst_n <= next_pd_rst_n;
      req <= next_req;
      req_wr <= next_req_wr;
      req_bsel <= next_req_bsel;
      req_addr <= next_req_addr;
      req_data <= next_req_data;
      reg_rdata <= next_reg_rdata;
      rb_s1 <= ready_busy_n_in;
      rb_s2 <= rb_s1;
    end
  end

  assign cyc.req = req;
  assign cyc.wr = req_wr;
  assign cyc.bsel = req_bsel;
  assign cyc.addr = req_addr;
  assign cyc.wdata = req_data;
  assign reg_rdata_out = reg_rdata;
  assign powerdown_reset_n_out = pd_rst_n;

  fcsi_bus_cycle u_fcsi_bus_cycle (
    .sys_clk_in (sys_clk_in),
    .sys_rst_in (sys_rst_in),
    .cyc        (cyc),
    .ce_n_out   (flash_ce_n_out),
    .oe_n_out   (flash_oe_n_out),
    .we_n_out   (flash_we_n_out),
    .addr_out   (flash_addr_out),
    .bsel_out   (byte_select_addr_out),
    .dq_out     (flash_dq_out),
    .dq_oe_out  (flash_dq_oe_out),
    .dq_in      (flash_dq_in)
  );

  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (sys_rst_in);
  sequence seq_poll_ready;
    state == S_POLL && cyc.done && rdy;
  endsequence

  AST_CLR_CODE: assert property (req && state == S_C1 && op == OP_CLR_STAT |-> req_wr && req_data[7:0] == CMD_CLR_STAT)
    else $error("clear status code wrong");
  AST_WORD_DATA: assert property (req && state == S_C2 && op == OP_WORD_WR |-> req_wr && req_data == wdata)
    else $error("word write data wrong");
  AST_ERASE_CONF: assert property (req && state == S_C2 && op == OP_ERASE |-> req_data[7:0] == CMD_CONFIRM && req_addr == addr[A_W-1:0])
    else $error("erase confirm wrong");
  AST_CONF_ADDR: assert property (req && state == S_C2 && (op == OP_PSET || op == OP_PRESET) |-> req_addr[9:0] == 10'h0ff)
    else $error("protect confirm address wrong");
  AST_LOCK_GUARD: assert property (state == S_IDLE && ctl_wr && reg_wdata_in[CTL_GO] && reg_wdata_in[OP_W-1:0] == OP_LOCK && !poff |=> state == S_IDLE && refused)
    else $error("lock started without protect reset");
  AST_LOCK_CHAIN: assert property (seq_poll_ready and op == OP_LOCK |=> state == S_C1 && op == OP_PSET)
    else $error("protect set did not follow lock");
  AST_POLL_WAIT: assert property (state == S_POLL && cyc.done && !rdy |=> state == S_POLL ##1 req)
    else $error("result taken before ready");
  AST_MASK: assert property (seq_poll_ready |=>
    stat_byte == ($past(cyc.rdata[7:0]) & STATUS_MASK) && stat_byte[2:0] == 3'h0)
    else $error("status not stored masked");
  AST_RESUME: assert property (seq_poll_ready and op == OP_SUSPEND |=> owe == !$past(cyc.rdata[STATUS_SUSP]))
    else $error("resume debt not tracked");
  AST_BYTE: assert property (req && state == S_C3 |-> req_bsel != addr[ADDR_BSEL] && req_wr)
    else $error("second byte select not inverted");
  AST_FF_END: assert property (state == S_FF && cyc.done |=> state == S_IDLE && rdata == $past(rdata))
    else $error("array read return missing");
endmodule : fcsi_host

// ===== fcsi_pkg.sv
// Constants, codes and state types of the flash command host.
// Assumes a 20 MHz system clock and a flash on plain asynchronous pins.
package fcsi_pkg;
  localparam int A_W  = 18;
  localparam int D_W  = 16;
  localparam int R_W  = 32;
  localparam int RA_W = 3;
  localparam int OP_W = 4;
  localparam int CLK_NS      = 50;
  localparam int T_SETUP_NS  = 50;
  localparam int T_STROBE_NS = 150;
  localparam int T_RECOV_NS  = 50;
  localparam int T_PD_NS     = 750;
  localparam int SYNC_CYC    = 2;
  localparam int SETUP_CYC   = (T_SETUP_NS + CLK_NS - 1) / CLK_NS;
  localparam int STROBE_CYC  = (T_STROBE_NS + CLK_NS - 1) / CLK_NS + SYNC_CYC;
  localparam int RECOV_CYC   = (T_RECOV_NS + CLK_NS - 1) / CLK_NS;
  localparam int PD_CYC      = (T_PD_NS + CLK_NS - 1) / CLK_NS;
  localparam logic [7:0] SETUP_LOAD  = 8'(SETUP_CYC - 1);
  localparam logic [7:0] STROBE_LOAD = 8'(STROBE_CYC - 1);
  localparam logic [7:0] RECOV_LOAD  = 8'(RECOV_CYC - 1);
  localparam logic [7:0] PD_LOAD     = 8'(PD_CYC - 1);
  // Own register map
  localparam logic [RA_W-1:0] REG_CTRL  = 3'h0;
  localparam logic [RA_W-1:0] REG_ADDR  = 3'h1;
  localparam logic [RA_W-1:0] REG_WDATA = 3'h2;
  localparam logic [RA_W-1:0] REG_STAT  = 3'h3;
  localparam logic [RA_W-1:0] REG_RDATA = 3'h4;
  localparam int CTL_GO   = 4;
  localparam int CTL_PDN  = 5;
  localparam int CTL_CLR  = 6;
  localparam int ADDR_BSEL = 18;
  localparam int ST_BUSY = 8;
  localparam int ST_SEQ  = 9;
  localparam int ST_REF  = 10;
  localparam int ST_OWE  = 11;
  localparam int ST_POFF = 12;
  localparam int ST_RB   = 13;
  localparam int ST_PDN  = 14;
  typedef logic [OP_W-1:0] fcsi_op_t;
  localparam fcsi_op_t OP_READ_ARRAY = 4'h0;
  localparam fcsi_op_t OP_READ_ID    = 4'h1;
  localparam fcsi_op_t OP_READ_STAT  = 4'h2;
  localparam fcsi_op_t OP_CLR_STAT   = 4'h3;
  localparam fcsi_op_t OP_WORD_WR    = 4'h4;
  localparam fcsi_op_t OP_ALT_WR     = 4'h5;
  localparam fcsi_op_t OP_ERASE      = 4'h6;
  localparam fcsi_op_t OP_SUSPEND    = 4'h7;
  localparam fcsi_op_t OP_RESUME     = 4'h8;
  localparam fcsi_op_t OP_PSET       = 4'h9;
  localparam fcsi_op_t OP_PRESET     = 4'ha;
  localparam fcsi_op_t OP_LOCK       = 4'hb;
  localparam fcsi_op_t OP_ERASE_ALL  = 4'hc;
  localparam fcsi_op_t OP_TWO_BYTE   = 4'hd;
  localparam logic [7:0] CMD_READ_ARRAY = 8'hff;
  localparam logic [7:0] CMD_READ_ID    = 8'h90;
  localparam logic [7:0] CMD_READ_STAT  = 8'h70;
  localparam logic [7:0] CMD_CLR_STAT   = 8'h50;
  localparam logic [7:0] CMD_WORD_WR    = 8'h40;
  localparam logic [7:0] CMD_ALT_WR     = 8'h10;
  localparam logic [7:0] CMD_ERASE      = 8'h20;
  localparam logic [7:0] CMD_SUSPEND    = 8'hb0;
  localparam logic [7:0] CMD_CONFIRM    = 8'hd0;
  localparam logic [7:0] CMD_PSET       = 8'h57;
  localparam logic [7:0] CMD_PRESET     = 8'h47;
  localparam logic [7:0] CMD_LOCK       = 8'h77;
  localparam logic [7:0] CMD_ERASE_ALL  = 8'ha7;
  localparam logic [7:0] CMD_TWO_BYTE   = 8'hfb;
  localparam logic [A_W-1:0] CONF_ADDR = 18'h000ff;
  localparam logic [7:0] STATUS_MASK = 8'hf8;
  localparam int STATUS_RDY  = 7;
  localparam int STATUS_SUSP = 6;
  localparam int STATUS_EERR = 5;
  localparam int STATUS_WERR = 4;
  typedef enum logic [8:0] {
    S_IDLE = 9'h001, S_C1 = 9'h002, S_C2 = 9'h004, S_C3 = 9'h008, S_STW = 9'h010,
    S_POLL = 9'h020, S_RES = 9'h040, S_FF = 9'h080, S_PDN = 9'h100
  } fcsi_state_e;
  typedef enum logic [3:0] {
    B_IDLE = 4'h1, B_SETUP = 4'h2, B_STROBE = 4'h4, B_RECOV = 4'h8
  } fcsi_bus_e;
endpackage : fcsi_pkg

// ===== fcsi_cyc_if.sv
// Carrier between the sequencer and the pin cycle engine.
// Request fields are valid in the cycle req is high; done is a one-cycle pulse.
interface fcsi_cyc_if;
  import fcsi_pkg::*;
  logic             req;
  logic             wr;
  logic             bsel;
  logic [A_W-1:0]   addr;
  logic [D_W-1:0]   wdata;
  logic             done;
  logic [D_W-1:0]   rdata;
  modport ctl (output req, wr, bsel, addr, wdata, input done, rdata);
  modport eng (input req, wr, bsel, addr, wdata, output done, rdata);
endinterface : fcsi_cyc_if

// ===== fcsi_bus_cycle.sv
// One asynchronous flash bus cycle per request: setup, strobe, recovery.
// Assumes req only while idle; data pins are sampled through two flops.
module fcsi_bus_cycle
(
  input  wire logic                 sys_clk_in,
  input  wire logic                 sys_rst_in,
  fcsi_cyc_if.eng                   cyc,
  output logic                      ce_n_out,
  output logic                      oe_n_out,
  output logic                      we_n_out,
  output logic [fcsi_pkg::A_W-1:0]  addr_out,
  output logic                      bsel_out,
  output logic [fcsi_pkg::D_W-1:0]  dq_out,
  output logic                      dq_oe_out,
  input  wire logic [fcsi_pkg::D_W-1:0] dq_in
);
  import fcsi_pkg::*;
  fcsi_bus_e        st, next_st;
  logic [7:0]       cnt, next_cnt;
  logic             wr, next_wr, done, next_done;
  logic             ce_n, next_ce_n, oe_n, next_oe_n, we_n, next_we_n;
  logic             dq_oe, next_dq_oe, bsel, next_bsel;
  logic [A_W-1:0]   addr, next_addr;
  logic [D_W-1:0]   dq, next_dq, rdata, next_rdata;
  logic [D_W-1:0]   dq_s1, dq_s2;

  always_comb
  begin
    next_st = st;
    next_cnt = cnt;
    next_wr = wr;
    next_done = 1'b0;
    next_ce_n = ce_n;
    next_oe_n = oe_n;
    next_we_n = we_n;
    next_dq_oe = dq_oe;
    next_bsel = bsel;
    next_addr = addr;
    next_dq = dq;
    next_rdata = rdata;
    unique case (st)
      B_IDLE:
        if (cyc.req)
        begin
          next_addr = cyc.addr;
          next_bsel = cyc.bsel;
          next_dq = cyc.wdata;
          next_wr = cyc.wr;
          next_ce_n = 1'b0;
          next_dq_oe = cyc.wr;
          next_cnt = SETUP_LOAD;
          next_st = B_SETUP;
        end
      B_SETUP:
        if (cnt == '0)
        begin
          next_we_n = !wr;
          next_oe_n = wr;
          next_cnt = STROBE_LOAD;
          next_st = B_STROBE;
        end
        else
          next_cnt = cnt - 8'h01;
      B_STROBE:
        if (cnt == '0)
        begin
          if (!wr)
            next_rdata = dq_s2;
          next_we_n = 1'b1;
          next_oe_n = 1'b1;
          next_cnt = RECOV_LOAD;
          next_st = B_RECOV;
        end
        else
          next_cnt = cnt - 8'h01;
      B_RECOV:
        if (cnt == '0)
        begin
          next_ce_n = 1'b1;
          next_dq_oe = 1'b0;
          next_done = 1'b1;
          next_st = B_IDLE;
        end
        else
          next_cnt = cnt - 8'h01;
    endcase
  end

  always_ff @(posedge sys_clk_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
    begin
      st <= B_IDLE;
      cnt <= '0;
      wr <= 1'b0;
      done <= 1'b0;
      ce_n <= 1'b1;
      oe_n <= 1'b1;
      we_n <= 1'b1;
      dq_oe <= 1'b0;
      bsel <= 1'b0;
      addr <= '0;
      dq <= '0;
      rdata <= '0;
      dq_s1 <= '0;
      dq_s2 <= '0;
    end
    else
    begin
      st <= next_st;
      cnt <= next_cnt;
      wr <= next_wr;
      done <= next_done;
      ce_n <= next_ce_n;
      oe_n <= next_oe_n;
      we_n <= next_we_n;
      dq_oe <= next_dq_oe;
      bsel <= next_bsel;
      addr <= next_addr;
      dq <= next_dq;
      rdata <= next_rdata;
      dq_s1 <= dq_in;
      dq_s2 <= dq_s1;
    end
  end

  assign cyc.done = done;
  assign cyc.rdata = rdata;
  assign ce_n_out = ce_n;
  assign oe_n_out = oe_n;
  assign we_n_out = we_n;
  assign addr_out = addr;
  assign bsel_out = bsel;
  assign dq_out = dq;
  assign dq_oe_out = dq_oe;

  AST_WE_FRAME: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
    !we_n |-> !ce_n && oe_n && dq_oe)
    else $error("write strobe outside a driven write frame");
  AST_NO_CLASH: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
    !oe_n |-> !dq_oe && !ce_n)
    else $error("output enable while host drives data");
endmodule : fcsi_bus_cycle

// ===== fcsi_flash_model.sv
// Behavioural flash device answering the host's pins.
// Assumes host pins change on the same clock; dq/addr held until ce rises.
module fcsi_flash_model #(
  parameter logic [15:0] MAKER_ID = 16'h005a, // Arbitrary value
  parameter logic [15:0] PART_ID  = 16'h0c3c  // Arbitrary value
)(
  input  wire logic        clk_in,
  input  wire logic        pd_rst_n_in,
  input  wire logic        ce_n_in,
  input  wire logic        oe_n_in,
  input  wire logic        we_n_in,
  input  wire logic [17:0] addr_in,
  input  wire logic [15:0] dq_in,
  input  wire logic        vpp_high_in,
  output logic      [15:0] dq_out,
  output logic             rb_low_out
);
  timeunit 1ns;
  timeprecision 1ns;
  // Power-up state: ready, array read, every block locked
  logic [7:0]  stat_byte = 8'h80;
  logic [7:0]  pend = 8'h00;
  logic [1:0]  mode = 2'd0;
  logic        locked = 1'b1;
  logic        wq = 1'b1;
  int          busy;
  logic [15:0] mem [256];
  logic [15:0] val;
  logic [15:0] last = '0;
  assign val = mode == 2'd0 ? mem[addr_in[7:0]] :
               mode == 2'd1 ? (addr_in[0] ? PART_ID : MAKER_ID) : {8'h00, stat_byte};
  assign dq_out = (!ce_n_in && !oe_n_in) ? val : ~last;
  assign rb_low_out = busy != 0;
  always @(posedge clk_in or negedge pd_rst_n_in)
    if (!pd_rst_n_in)
    begin
      stat_byte <= 8'h80;
      {mode, pend, busy, wq} <= '0;
      locked <= 1'b1;
    end
    else
    begin
      wq <= we_n_in;
      if (!ce_n_in && !oe_n_in)
        last <= val;
      if (busy > 1)
        busy <= busy - 1;
      else if (busy == 1)
      begin
        busy <= 0;
        stat_byte[7] <= 1'b1;
      end
      if (we_n_in && !wq && !ce_n_in)
        if (pend == 8'h00)
          case (dq_in[7:0])
            8'hff: mode <= 2'd0;
            8'h90: mode <= 2'd1;
            8'h70: mode <= 2'd2;
            8'h50: stat_byte[5:3] <= 3'h0;
            8'hb0, 8'hd0: mode <= 2'd2;
            default: pend <= dq_in[7:0];
          endcase
        else
        begin
          pend <= 8'h00;
          mode <= 2'd2;
          if ((pend == 8'h57 || pend == 8'h47) && addr_in[9:0] == 10'h0ff && dq_in[7:0] == 8'hd0)
            locked <= 1'b0;
          else if (!vpp_high_in)
            stat_byte <= 8'h88;
          else if (locked && pend != 8'ha7)
            stat_byte <= 8'hb0;
          else if (pend == 8'h40 || pend == 8'h10)
          begin
            mem[addr_in[7:0]] <= dq_in;
            stat_byte <= 8'h00;
            busy <= 8;
          end
          else if ((pend == 8'h20 || pend == 8'ha7 || pend == 8'h77) && dq_in[7:0] == 8'hd0)
          begin
            stat_byte <= 8'h00;
            busy <= 60;
          end
          else
            stat_byte[5:4] <= 2'b11;
        end
    end
endmodule : fcsi_flash_model

// ===== fcsi_host_tb.sv
// Self-checking bench of the flash command host.
// Assumes the flash model behind the pins; ready/busy is driven as the inverse of its rb_low_out.
module fcsi_host_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic sys_clk_in = 0, sys_rst_in = 1, reg_wr_in = 0, reg_rd_in = 0, vpp = 1;
  logic [2:0] reg_addr_in = '0;
  logic [31:0] reg_wdata_in = '0, reg_rdata_out, v;
  logic flash_ce_n_out, flash_oe_n_out, flash_we_n_out, byte_select_addr_out, flash_dq_oe_out;
  logic powerdown_reset_n_out, ready_busy_n_in, rb_low;
  logic [17:0] flash_addr_out;
  logic [15:0] flash_dq_out, flash_dq_in;
  int error_cnt = 0, samples_checked = 0;
  always #25 sys_clk_in = ~sys_clk_in;
  assign ready_busy_n_in = ~rb_low;
  fcsi_host u_fcsi_host (.sys_clk_in, .sys_rst_in, .reg_addr_in, .reg_wdata_in, .reg_wr_in, .reg_rd_in,
    .reg_rdata_out, .flash_ce_n_out, .flash_oe_n_out, .flash_we_n_out, .flash_addr_out, .byte_select_addr_out,
    .flash_dq_out, .flash_dq_oe_out, .flash_dq_in, .powerdown_reset_n_out, .ready_busy_n_in);
  fcsi_flash_model u_fcsi_flash_model (.clk_in(sys_clk_in), .pd_rst_n_in(powerdown_reset_n_out),
    .ce_n_in(flash_ce_n_out), .oe_n_in(flash_oe_n_out), .we_n_in(flash_we_n_out), .addr_in(flash_addr_out),
    .dq_in(flash_dq_out), .vpp_high_in(vpp), .dq_out(flash_dq_in), .rb_low_out(rb_low));
  task automatic wr(input logic [2:0] a, input logic [31:0] d);
    @(posedge sys_clk_in);
    {reg_addr_in, reg_wdata_in, reg_wr_in} <= {a, d, 1'b1};
    @(posedge sys_clk_in);
    reg_wr_in <= 1'b0;
  endtask : wr
  task automatic rd(input logic [2:0] a);
    @(posedge sys_clk_in);
    {reg_addr_in, reg_rd_in} <= {a, 1'b1};
    @(posedge sys_clk_in);
    reg_rd_in <= 1'b0;
    #1 v = reg_rdata_out;
  endtask : rd
  task automatic chk(input string n, input logic [31:0] m, input logic [31:0] e);
    samples_checked++;
    if ((v & m) !== e)
    begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", n, e, v & m);
    end
  endtask : chk
  task automatic wait_idle;
    for (int i = 0; i < 500; i++)
    begin
      rd(3'h3);
      if (v[8] === 1'b0)
        return;
    end
    error_cnt++;
    $display("[ERR] busy_poll expected 0 seen 1");
  endtask : wait_idle
  task automatic op(input logic [3:0] o, input logic [31:0] a, input logic [31:0] d);
    wr(3'h1, a);
    wr(3'h2, d);
    wr(3'h0, {27'h0, 1'b1, o});
    repeat (3) @(posedge sys_clk_in);
    wait_idle;
  endtask : op
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : report_and_stop
  initial
  begin
    #1000000;
    error_cnt++;
    report_and_stop;
  end
  initial
  begin
    repeat (3) @(posedge sys_clk_in);
    sys_rst_in <= 1'b0;
    rd(3'h3);
    chk("stat_reset", 32'hffffffff, 32'h2000);
    op(4'h4, 5, 16'h1234);
    chk("locked_write", 32'hff, 32'hb0);
    op(4'h3, 0, 0);
    op(4'h2, 0, 0);
    rd(3'h4);
    chk("clear_status", 32'hf8, 32'h80);
    op(4'ha, 0, 0);
    chk("preset_flag", 32'h1000, 32'h1000);
    op(4'h4, 5, 16'h1234);
    chk("write_ok", 32'hff, 32'h80);
    op(4'h0, 5, 0);
    rd(3'h4);
    chk("array_read", 32'hffff, 32'h1234);
    op(4'h1, 0, 0);
    rd(3'h4);
    chk("maker_id", 32'hffff, 32'h005a);
    op(4'h1, 1, 0);
    rd(3'h4);
    chk("part_id", 32'hffff, 32'h0c3c);
    $display("test done: id and write");
    vpp <= 1'b0;
    op(4'h4, 6, 16'h5555);
    chk("supply_low", 32'hff, 32'h88);
    vpp <= 1'b1;
    op(4'h3, 0, 0);
    wr(3'h1, 32'h40);
    wr(3'h0, 32'h16);
    repeat (40) @(posedge sys_clk_in);
    rd(3'h3);
    chk("busy_pin", 32'h2100, 32'h0100);
    wait_idle;
    chk("erase_done", 32'hff, 32'h80);
    op(4'hb, 32'h40, 0);
    chk("lock_chain", 32'h10ff, 32'h80);
    wr(3'h0, 32'h20);
    repeat (3) @(posedge sys_clk_in);
    rd(3'h3);
    chk("powerdown", 32'h50ff, 32'h4000);
    wr(3'h0, 32'h0);
    repeat (30) @(posedge sys_clk_in);
    op(4'hb, 32'h40, 0);
    chk("lock_refused", 32'h400, 32'h400);
    op(4'h7, 0, 0);
    chk("resume_owed", 32'h800, 32'h800);
    op(4'hc, 0, 0);
    chk("erase_all", 32'h8ff, 32'h80);
    $display("test done: supply, erase, powerdown");
    report_and_stop;
  end
endmodule : fcsi_host_tb
